/* File: hw/serial_irq_level_edge_status.sv */
// Function
// RULE_01: Each of lines 0 to 15 has a trigger-select bit; 0 edge, 1 level.
// RULE_02: Link reset, global reset or power-on reset clear selects and flags.
// RULE_03: A signaled level-mode line sets its status flag at its bit position.
// RULE_04: Writing one to a set flag clears it and re-arms the line.
// RULE_05: Edge-mode lines never set a status flag.
// RULE_06: Status reads at 4Ch in memory window and E4h in configuration alias.
// RULE_07: Writing zero leaves a flag unchanged; one to a clear flag does nothing.
// RULE_08: Start frame lasts 4, 6 or 8 clocks per two-bit width setting.
// RULE_09: Poll setting zero runs continuous mode, one runs quiet mode.
`timescale 1ns/1ns
`default_nettype none

module serial_irq_level_edge_status (
  input  wire logic        CLK_I,            // System clock, 125 MHz.
  input  wire logic        RST_N_I,          // Power-on reset, synchronous, active low.
  input  wire logic        LINK_RST_N_I,     // Link reset pin, active low.
  input  wire logic        GLOBAL_RST_N_I,   // Global reset pin, active low.
  input  wire logic        REG_CFG_SPACE_I,  // 1 selects configuration alias, 0 memory window.
  input  wire logic [7:0]  REG_ADDR_I,       // Register byte offset.
  input  wire logic        REG_WR_I,         // Register write strobe.
  input  wire logic        REG_RD_I,         // Register read strobe.
  input  wire logic [15:0] REG_WDATA_I,      // Register write data.
  input  wire logic [15:0] LINE_REQ_I,       // One-cycle request per decoded line.
  input  wire logic        FRAME_END_I,      // Stop frame finished, one-cycle pulse.
  input  wire logic        START_REQ_I,      // Quiet-mode start request.
  output logic [15:0]      REG_RDATA_O,      // Read data, valid the cycle after the strobe.
  output logic [15:0]      LEVEL_FLAGS_O,    // Current level status flags.
  output logic [15:0]      EDGE_REQ_O,       // Edge-mode requests passed on, one cycle.
  output logic             SIRQ_O,           // Serial stream output level.
  output logic             SIRQ_OE_N_O       // Serial stream enable, low while driving.
);

  // Decode one register that appears in both address spaces.
  function automatic logic hit(input logic       cfg_space,
                               input logic [7:0] addr,
                               input logic [7:0] win_off,
                               input logic [7:0] cfg_off);
    hit = cfg_space ? (addr == cfg_off) : (addr == win_off);
  endfunction

  logic        link_rst_s1_reg;
  logic        link_rst_s2_reg;
  logic        glob_rst_s1_reg;
  logic        glob_rst_s2_reg;
  logic        clr;
  logic [15:0] trig_reg;
  logic [15:0] trig_next;
  logic [15:0] flags_reg;
  logic [15:0] flags_next;
  logic [3:0]  mode_reg;
  logic [3:0]  mode_next;
  logic        kick_reg;
  logic        hit_mode;
  logic        hit_trig;
  logic        hit_flag;
  logic [15:0] level_set;
  logic [15:0] flag_clr;
  logic [15:0] rd_mux;
  logic        quiet;
  logic        frame_busy;
  logic        frame_start;

  // Bring the two reset pins into the clock domain.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      link_rst_s1_reg <= 1'b0;
      link_rst_s2_reg <= 1'b0;
      glob_rst_s1_reg <= 1'b0;
      glob_rst_s2_reg <= 1'b0;
    end else begin
      link_rst_s1_reg <= ~LINK_RST_N_I;
      link_rst_s2_reg <= link_rst_s1_reg;
      glob_rst_s1_reg <= ~GLOBAL_RST_N_I;
      glob_rst_s2_reg <= glob_rst_s1_reg;
    end
  end

  // Any of the three reset sources clears the block.
  // RULE_02: three reset sources
  assign clr = ~RST_N_I | link_rst_s2_reg | glob_rst_s2_reg;

  // Address decode, same three registers at different offsets in each space.
  // RULE_06: status in both spaces
  assign hit_mode = hit(REG_CFG_SPACE_I, REG_ADDR_I, sirq_pkg::WIN_MODE_OFF,
                        sirq_pkg::CFG_MODE_OFF);
  assign hit_trig = hit(REG_CFG_SPACE_I, REG_ADDR_I, sirq_pkg::WIN_TRIG_OFF,
                        sirq_pkg::CFG_TRIG_OFF);
  assign hit_flag = hit(REG_CFG_SPACE_I, REG_ADDR_I, sirq_pkg::WIN_FLAG_OFF,
                        sirq_pkg::CFG_FLAG_OFF);

  // Trigger select and mode register writes.
  // RULE_01: per-line trigger select
  assign trig_next = (REG_WR_I && hit_trig) ? REG_WDATA_I : trig_reg;
  assign mode_next = (REG_WR_I && hit_mode) ?
                     REG_WDATA_I[sirq_pkg::MODE_WIDTH_MSB:sirq_pkg::MODE_DRIVE_BIT] :
                     mode_reg;

  // Only level-mode lines record a flag; edge-mode lines are passed on instead.
  // RULE_03: level lines set flags
  // RULE_05: edge lines never flag
  assign level_set = LINE_REQ_I & trig_reg;

  // Ones written to the status register clear; a new request in the same cycle wins.
  // RULE_04: write one re-arms
  // RULE_07: zero writes keep flags
  assign flag_clr   = (REG_WR_I && hit_flag) ? REG_WDATA_I : 16'h0000;
  assign flags_next = (flags_reg & ~flag_clr) | level_set;

  // Read data selection; unmapped offsets and reserved bits read zero.
  assign rd_mux = hit_flag ? flags_reg :
                  hit_trig ? trig_reg  :
                  hit_mode ? {12'h000, mode_reg} :
                             16'h0000;

  // Configuration and status registers.
  always_ff @(posedge CLK_I) begin
    if (clr) begin
      trig_reg  <= sirq_pkg::TRIG_RESET;
      flags_reg <= sirq_pkg::FLAG_RESET;
      mode_reg  <= sirq_pkg::MODE_RESET;
    end else begin
      trig_reg  <= trig_next;
      flags_reg <= flags_next;
      mode_reg  <= mode_next;
    end
  end

  // Registered read data and pass-on of edge requests.
  always_ff @(posedge CLK_I) begin
    if (clr) begin
      REG_RDATA_O <= 16'h0000;
      EDGE_REQ_O  <= 16'h0000;
    end else begin
      REG_RDATA_O <= REG_RD_I ? rd_mux : 16'h0000;
      EDGE_REQ_O  <= LINE_REQ_I & ~trig_reg;
    end
  end

  assign LEVEL_FLAGS_O = flags_reg;

  // Continuous mode restarts after each frame; quiet mode waits for a request.
  // RULE_09: continuous or quiet
  assign quiet       = mode_reg[sirq_pkg::MODE_QUIET_BIT];
  assign frame_start = ~frame_busy & (quiet ? START_REQ_I : (kick_reg | FRAME_END_I));

  // First continuous frame is launched once the block leaves reset.
  always_ff @(posedge CLK_I) begin
    if (clr) begin
      kick_reg <= 1'b1;
    end else if (frame_start) begin
      kick_reg <= 1'b0;
    end
  end

  // Start frame driver.
  // RULE_08: start frame width
  sirq_start_frame u_start (
    .clk_i       (CLK_I),
    .clr_n_i     (~clr),
    .start_i     (frame_start),
    .width_sel_i (mode_reg[sirq_pkg::MODE_WIDTH_MSB:sirq_pkg::MODE_WIDTH_LSB]),
    .tristate_i  (mode_reg[sirq_pkg::MODE_DRIVE_BIT]),
    .line_o      (SIRQ_O),
    .line_oe_n_o (SIRQ_OE_N_O),
    .busy_o      (frame_busy)
  );

  a_reset_clears_all: assert property ( // RULE_02
    @(posedge CLK_I) (link_rst_s2_reg || glob_rst_s2_reg)
    |=> (trig_reg == 16'h0000 && flags_reg == 16'h0000))
    else $error("Reset source did not clear selects and flags.");

  a_trig_write_takes: assert property ( // RULE_01
    @(posedge CLK_I) disable iff (clr)
    (REG_WR_I && hit_trig) |=> trig_reg == $past(REG_WDATA_I))
    else $error("Trigger select write not stored.");

  a_level_sets_flag: assert property ( // RULE_03
    @(posedge CLK_I) disable iff (clr)
    (|(LINE_REQ_I & trig_reg)) |=> ((flags_reg & $past(level_set)) == $past(level_set)))
    else $error("Level request did not set its flag.");

  a_edge_never_flags: assert property ( // RULE_05
    @(posedge CLK_I) disable iff (clr)
    1'b1 |=> ((flags_reg & ~$past(flags_reg) & ~$past(trig_reg)) == 16'h0000))
    else $error("Edge-mode line set a status flag.");

  a_one_clears_flag: assert property ( // RULE_04
    @(posedge CLK_I) disable iff (clr)
    (REG_WR_I && hit_flag) |=> ((flags_reg & $past(REG_WDATA_I) & ~$past(level_set)) == 16'h0000))
    else $error("Written one did not clear the flag.");

  a_zero_keeps_flag: assert property ( // RULE_07
    @(posedge CLK_I) disable iff (clr)
    (REG_WR_I && hit_flag) |=> ((flags_reg & ~$past(REG_WDATA_I)) ==
                                ($past(flags_reg | level_set) & ~$past(REG_WDATA_I))))
    else $error("Zero write changed a flag.");

  a_flag_read_alias: assert property ( // RULE_06
    @(posedge CLK_I) disable iff (clr)
    (REG_RD_I && hit_flag) |=> REG_RDATA_O == $past(flags_reg))
    else $error("Status read returned wrong value.");

  a_quiet_needs_req: assert property ( // RULE_09
    @(posedge CLK_I) disable iff (clr)
    (frame_start && quiet) |-> START_REQ_I)
    else $error("Quiet mode started a frame without a request.");

  a_continuous_restart: assert property ( // RULE_09
    @(posedge CLK_I) disable iff (clr)
    (!quiet && FRAME_END_I && !frame_busy) |=> !SIRQ_OE_N_O && !SIRQ_O)
    else $error("Continuous mode did not restart the frame.");

endmodule

`default_nettype wire

/* File: hw/sirq_pkg.sv */
package sirq_pkg;

  // Register port widths and line count.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int LINES  = 16;

  // Register offsets in the device-control memory window.
  localparam logic [7:0] WIN_MODE_OFF = 8'h48;
  localparam logic [7:0] WIN_TRIG_OFF = 8'h4A;
  localparam logic [7:0] WIN_FLAG_OFF = 8'h4C;

  // Register offsets in the configuration-space alias.
  localparam logic [7:0] CFG_MODE_OFF = 8'hE0;
  localparam logic [7:0] CFG_TRIG_OFF = 8'hE2;
  localparam logic [7:0] CFG_FLAG_OFF = 8'hE4;

  // Reset values.
  localparam logic [15:0] TRIG_RESET = 16'h0000;
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [3:0]  MODE_RESET = 4'h0;

  // Mode register field positions; bits 7:4 read as zero.
  localparam int MODE_DRIVE_BIT = 0;
  localparam int MODE_QUIET_BIT = 1;
  localparam int MODE_WIDTH_LSB = 2;
  localparam int MODE_WIDTH_MSB = 3;

  // Start frame width encodings and their lengths in clocks.
  localparam logic [1:0] WIDTH_SEL_4 = 2'h0;
  localparam logic [1:0] WIDTH_SEL_6 = 2'h1;
  localparam logic [1:0] WIDTH_SEL_8 = 2'h2;
  localparam logic [3:0] START_LEN_4 = 4'h4;
  localparam logic [3:0] START_LEN_6 = 4'h6;
  localparam logic [3:0] START_LEN_8 = 4'h8;

endpackage

/* File: hw/sirq_start_frame.sv */
`timescale 1ns/1ns
`default_nettype none

module sirq_start_frame (
  input  wire logic       clk_i,        // System clock.
  input  wire logic       clr_n_i,      // Synchronous clear, active low.
  input  wire logic       start_i,      // Launch a start frame.
  input  wire logic [1:0] width_sel_i,  // Start frame width setting.
  input  wire logic       tristate_i,   // Release rather than drive high in recovery.
  output logic            line_o,       // Serial line output level.
  output logic            line_oe_n_o,  // Output enable, low while driving.
  output logic            busy_o        // A start frame is in progress.
);

  typedef enum logic [1:0] {IDLE, START, RECOVER} frame_state_type;

  frame_state_type state_reg;
  frame_state_type state_next;
  logic [3:0]      cnt_reg;
  logic [3:0]      cnt_next;
  logic [3:0]      start_len;
  logic            line_next;
  logic            oe_n_next;

  // Width setting to length; the reserved code falls back to the shortest frame.
  // RULE_08: start width decode
  assign start_len = (width_sel_i == sirq_pkg::WIDTH_SEL_6) ? sirq_pkg::START_LEN_6 :
                     (width_sel_i == sirq_pkg::WIDTH_SEL_8) ? sirq_pkg::START_LEN_8 :
                                                              sirq_pkg::START_LEN_4;

  // Next state, counter and pin values.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    line_next  = 1'b1;
    oe_n_next  = 1'b1;
    case (state_reg)
      IDLE: begin
        if (start_i) begin
          state_next = START;
          cnt_next   = start_len - 4'h1;
          line_next  = 1'b0;
          oe_n_next  = 1'b0;
        end
      end
      START: begin
        if (cnt_reg == 4'h0) begin
          state_next = RECOVER;
          oe_n_next  = tristate_i;
        end else begin
          cnt_next  = cnt_reg - 4'h1;
          line_next = 1'b0;
          oe_n_next = 1'b0;
        end
      end
      RECOVER: begin
        state_next = IDLE;
      end
      default: begin
        state_next = IDLE;
      end
    endcase
  end

  // State and pin registers.
  always_ff @(posedge clk_i) begin
    if (!clr_n_i) begin
      state_reg   <= IDLE;
      cnt_reg     <= 4'h0;
      line_o      <= 1'b1;
      line_oe_n_o <= 1'b1;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      line_o      <= line_next;
      line_oe_n_o <= oe_n_next;
    end
  end

  assign busy_o = (state_reg != IDLE);

  // Line held low for exactly four or eight clocks, for the four- and eight-clock width settings.
  sequence low_run_4;
    (!line_o && !line_oe_n_o)[*4] ##1 line_o;
  endsequence

  sequence low_run_8;
    (!line_o && !line_oe_n_o)[*8] ##1 line_o;
  endsequence

  a_start_four_clocks: assert property ( // RULE_08
    @(posedge clk_i) disable iff (!clr_n_i)
    (start_i && !busy_o && width_sel_i == sirq_pkg::WIDTH_SEL_4) |=> low_run_4)
    else $error("Start frame is not four clocks long.");

  a_start_eight_clocks: assert property ( // RULE_08
    @(posedge clk_i) disable iff (!clr_n_i)
    (start_i && !busy_o && width_sel_i == sirq_pkg::WIDTH_SEL_8) |=> low_run_8)
    else $error("Start frame is not eight clocks long.");

endmodule

`default_nettype wire

/* File: testbench/serial_irq_level_edge_status_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module serial_irq_level_edge_status_tb;
  logic CLK_I = 1'b0, RST_N_I = 1'b0, LINK_RST_N_I = 1'b1, GLOBAL_RST_N_I = 1'b1;
  logic REG_CFG_SPACE_I = 1'b0, REG_WR_I = 1'b0, REG_RD_I = 1'b0, START_REQ_I = 1'b0;
  logic [7:0]  REG_ADDR_I = 8'h00;
  logic [15:0] REG_WDATA_I = 16'h0000;
  logic [15:0] LINE_REQ_I, REG_RDATA_O, LEVEL_FLAGS_O, EDGE_REQ_O;
  logic FRAME_END_I, SIRQ_O, SIRQ_OE_N_O;
  logic en = 1'b0, chk_on = 1'b0, pin_clr = 1'b0;
  logic [15:0] m_trig = 16'h0000, m_flags = 16'h0000, m_edge = 16'h0000, d;
  int n_mismatch = 0, checks_done = 0, seed = 32'h0000A8C7, it, ok;

  always #4 CLK_I = ~CLK_I;

  serial_irq_level_edge_status uut (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .LINK_RST_N_I(LINK_RST_N_I), .GLOBAL_RST_N_I(GLOBAL_RST_N_I),
    .REG_CFG_SPACE_I(REG_CFG_SPACE_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I), .LINE_REQ_I(LINE_REQ_I),
    .FRAME_END_I(FRAME_END_I), .START_REQ_I(START_REQ_I), .REG_RDATA_O(REG_RDATA_O),
    .LEVEL_FLAGS_O(LEVEL_FLAGS_O), .EDGE_REQ_O(EDGE_REQ_O), .SIRQ_O(SIRQ_O),
    .SIRQ_OE_N_O(SIRQ_OE_N_O));

  sirq_far_devices far (.clk_i(CLK_I), .en_i(en), .line_req_o(LINE_REQ_I),
    .frame_end_o(FRAME_END_I));

  // Reference model of selects, level flags and edge pulses.
  always @(posedge CLK_I) begin
    if (!RST_N_I || pin_clr) begin
      m_trig = 16'h0000;
      m_flags = 16'h0000;
      m_edge = 16'h0000;
    end else begin
      m_edge = LINE_REQ_I & ~m_trig;
      if (REG_WR_I && REG_ADDR_I == (REG_CFG_SPACE_I ? 8'hE4 : 8'h4C))
        m_flags = m_flags & ~REG_WDATA_I;
      m_flags = m_flags | (LINE_REQ_I & m_trig);
      if (REG_WR_I && REG_ADDR_I == (REG_CFG_SPACE_I ? 8'hE2 : 8'h4A))
        m_trig = REG_WDATA_I;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic cfg, input logic [7:0] a, input logic [15:0] v);
    @(posedge CLK_I);
    REG_WR_I <= 1'b1;
    REG_CFG_SPACE_I <= cfg;
    REG_ADDR_I <= a;
    REG_WDATA_I <= v;
    @(posedge CLK_I);
    REG_WR_I <= 1'b0;
    // Return off the edge so the reference model has taken the write before the caller reads it.
    @(negedge CLK_I);
  endtask

  task automatic rd(input logic cfg, input logic [7:0] a, input logic [15:0] exp);
    @(posedge CLK_I);
    REG_RD_I <= 1'b1;
    REG_CFG_SPACE_I <= cfg;
    REG_ADDR_I <= a;
    @(posedge CLK_I);
    REG_RD_I <= 1'b0;
    @(negedge CLK_I);
    chk("read data", exp, REG_RDATA_O);
  endtask

  // Waits for an idle-to-driven step, so a frame already under way is never measured.
  task automatic frame_chk(input logic [1:0] wc, input logic drv);
    int   k, n;
    logic idle;
    n = 0;
    idle = 1'b0;
    @(negedge CLK_I);
    for (k = 0; k < 96 && !(idle && SIRQ_OE_N_O === 1'b0); k++) begin
      idle = (SIRQ_OE_N_O === 1'b1);
      @(negedge CLK_I);
    end
    if (k == 96) begin
      n_mismatch++;
      wrap_up();
    end
    while (SIRQ_O === 1'b0 && n < 16) begin
      n++;
      @(negedge CLK_I);
    end
    chk("start width", (wc == 2'h1) ? 16'h0006 : (wc == 2'h2) ? 16'h0008 : 16'h0004, 16'(n));
    chk("recovery enable", {15'h0000, drv}, {15'h0000, SIRQ_OE_N_O});
  endtask

  // Every cycle with chk_on set, the flags and edge pulses follow the model.
  always @(negedge CLK_I) begin
    if (chk_on) begin
      chk("level flags", m_flags, LEVEL_FLAGS_O);
      chk("edge requests", m_edge, EDGE_REQ_O);
    end
  end

  // Main sequence: registers, line traffic, frames, pin resets.
  initial begin
    repeat (12) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    @(posedge CLK_I);
    chk_on = 1'b1;
    rd(1'b0, sirq_pkg::WIN_FLAG_OFF, 16'h0000);
    rd(1'b1, sirq_pkg::CFG_FLAG_OFF, 16'h0000);
    rd(1'b0, sirq_pkg::WIN_TRIG_OFF, 16'h0000);
    for (it = 0; it < 6; it++) begin
      d = 16'($random(seed));
      wr(it[0], it[0] ? sirq_pkg::CFG_TRIG_OFF : sirq_pkg::WIN_TRIG_OFF, d);
      rd(~it[0], it[0] ? sirq_pkg::WIN_TRIG_OFF : sirq_pkg::CFG_TRIG_OFF, d);
      en <= 1'b1;
      repeat (20) @(posedge CLK_I);
      en <= 1'b0;
      repeat (2) @(posedge CLK_I);
      rd(1'b1, sirq_pkg::CFG_FLAG_OFF, m_flags);
      rd(1'b0, sirq_pkg::WIN_FLAG_OFF, m_flags);
      wr(it[1], it[1] ? sirq_pkg::CFG_FLAG_OFF : sirq_pkg::WIN_FLAG_OFF, 16'($random(seed)));
      rd(1'b0, sirq_pkg::WIN_FLAG_OFF, m_flags);
      wr(1'b0, 8'h50, 16'hFFFF);
      rd(1'b0, 8'h50, 16'h0000);
    end
    for (it = 0; it < 4; it++) begin
      wr(1'b0, sirq_pkg::WIN_MODE_OFF, {12'h000, it[1:0], 1'b0, it[0]});
      repeat (40) @(posedge CLK_I);
      frame_chk(it[1:0], it[0]);
    end
    wr(1'b1, sirq_pkg::CFG_MODE_OFF, 16'h0006);
    ok = 1;
    repeat (40) begin
      @(negedge CLK_I);
      if (SIRQ_OE_N_O !== 1'b1) ok = 0;
    end
    chk("quiet idle", 16'h0001, 16'(ok));
    // The watcher sees the idle line before the request lands.
    fork
      frame_chk(2'h1, 1'b0);
      begin
        @(posedge CLK_I);
        START_REQ_I <= 1'b1;
        @(posedge CLK_I);
        START_REQ_I <= 1'b0;
      end
    join
    for (it = 0; it < 2; it++) begin
      wr(1'b0, sirq_pkg::WIN_TRIG_OFF, 16'hFFFF);
      en <= 1'b1;
      repeat (10) @(posedge CLK_I);
      en <= 1'b0;
      @(posedge CLK_I);
      chk_on = 1'b0;
      if (it == 0) GLOBAL_RST_N_I <= 1'b0;
      else LINK_RST_N_I <= 1'b0;
      pin_clr <= 1'b1;
      repeat (2) @(posedge CLK_I);
      GLOBAL_RST_N_I <= 1'b1;
      LINK_RST_N_I <= 1'b1;
      repeat (6) @(posedge CLK_I);
      pin_clr <= 1'b0;
      chk_on = 1'b1;
      rd(1'b0, sirq_pkg::WIN_TRIG_OFF, 16'h0000);
      rd(1'b1, sirq_pkg::CFG_FLAG_OFF, 16'h0000);
    end
    wrap_up();
  end
endmodule

`default_nettype wire

/* File: testbench/sirq_far_devices.sv */
`timescale 1ns/1ns
`default_nettype none

module sirq_far_devices (
  input  wire logic        clk_i,        // System clock.
  input  wire logic        en_i,         // Allow line requests.
  output logic [15:0]      line_req_o,   // One-cycle request per line.
  output logic             frame_end_o   // Stop frame finished pulse.
);
  int         seed = 32'h0000A8C7;
  logic [4:0] cnt  = 5'h00;

  // Devices request sparsely, and a frame ends every 32 clocks.
  initial line_req_o = 16'h0000;
  initial frame_end_o = 1'b0;
  always @(posedge clk_i) begin
    line_req_o  <= en_i ? 16'($random(seed) & $random(seed)) : 16'h0000;
    cnt         <= cnt + 5'h01;
    frame_end_o <= (cnt == 5'h1F);
  end
endmodule

`default_nettype wire
